/* src/sck_pkg.sv */
package sck_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [31:0] SCC_OFS = 32'h0000_0000;
  localparam logic [31:0] POWER_CTRL_REG_OFS = 32'h0000_0004;
  localparam logic [31:0] OSC_OFS = 32'h0000_0008;
  localparam logic [31:0] STAT_OFS = 32'h0000_000C;

  typedef enum logic [2:0] {
    IDX_SCC = 3'b000,
    IDX_POWER_CTRL_REG = 3'b001,
    IDX_OSC = 3'b010,
    IDX_STAT = 3'b011,
    IDX_NONE = 3'b111
  } sck_idx_t;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int SCC_SEL_LSB = 5;
  localparam int SCC_HS_SRC = 3;
  localparam int SCC_HS_KEEP = 1;
  localparam int SCC_LS_KEEP = 0;
  localparam int POWER_CTRL_REG_DPD = 0;
  localparam int OSC_XEN = 0;
  localparam int OSC_RPU = 1;
  localparam int OSC_XDIV2 = 2;
  localparam int OSC_XHALF = 3;
  localparam int OSC_FRC_EN = 4;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_CPU = 3;
  localparam int STAT_LDO = 4;
  localparam int STAT_HS = 5;
  localparam int STAT_SUB = 6;
  localparam int STAT_SYS = 7;
  localparam int STAT_SLOW_RC_OSC = 8;

  // ----------------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] SEL_RST = 3'h1;
  localparam logic [2:0] SEL_SUB = 3'h7;
  localparam logic [2:0] EXP_NONE = 3'h0;
  localparam logic FRC_EN_RST = 1'h1;
  localparam int OSC_XTAL = 0;
  localparam int OSC_FRC = 1;
  localparam int OSC_SLOW = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_SLOW = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_IDLE_LP = 3'b011,
    MODE_IDLE_BOTH = 3'b100,
    MODE_IDLE_HS = 3'b101,
    MODE_DEEP = 3'b110
  } sck_mode_t;

endpackage

/* src/sck_pow2_div.sv */
`timescale 1ns/1ps
module sck_pow2_div (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Source level, already synchronised, and requested power of two.
  input wire logic src_lvl,
  input wire logic [2:0] div_exp,
  // Divided level.
  output logic div_lvl
);

  typedef struct packed {
    logic prev;
    logic [6:0] cnt;
    logic [2:0] exp_act;
    logic lvl;
  } sck_div_st_t;

  sck_div_st_t s_q;
  sck_div_st_t s_d;

  function automatic logic tap(input logic [6:0] cnt, input logic src,
                               input logic [2:0] e);
    logic [7:0] taps;
    taps = {cnt, src};
    return taps[e];
  endfunction

  always_comb begin
    logic [6:0] cnt_n;
    cnt_n = s_q.cnt;
    s_d = s_q;
    s_d.prev = src_lvl;
    if (src_lvl && !s_q.prev) begin
      cnt_n = s_q.cnt + 7'h01;
    end
    s_d.cnt = cnt_n;
    // A new ratio is taken only while the old and new outputs are low.
    if (div_exp != s_q.exp_act && !s_q.lvl &&
        !tap(cnt_n, src_lvl, div_exp)) begin
      s_d.exp_act = div_exp;
    end
    s_d.lvl = tap(cnt_n, src_lvl, s_d.exp_act);
    if (!aresetn) begin
      s_d = '0;
    end
  end

  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  assign div_lvl = s_q.lvl;

endmodule

/* src/sck_top.sv */
`timescale 1ns/1ps
// What this block does
// - System clock is high-speed clock divided 1 to 64, or sub clock at 111.
// - High-speed clock comes from crystal or fast RC oscillator.
// - Source select 0 picks fast RC, 1 picks crystal.
// - Crystal runs only when both its enable and radio power-up are set.
// - Crystal frequency may be halved or quartered by two select bits.
// - Sub clock is derived from slow RC oscillator only.
// - In slow mode high-speed oscillator follows its own enable bit.
// - Deep sleep clocks time base 0 from slow RC, gated by watchdog.
// - Seven modes; CPU runs only in normal and slow.
// - Normal mode: regulator on, high-speed, sub and slow RC clocks run.
// - Slow mode: regulator on, CPU clocked from sub clock.
// - Stop with both keeps and deep power-down low enters sleep.
// - Stop with only low-speed keep enters low-speed idle.
// - Stop with both keeps high enters idle with both clocks.
// - Stop with only high-speed keep enters high-speed idle.
// - Stop with deep power-down enters deep sleep, regulator off.
// - Sleep and deep sleep run slow RC only when watchdog enabled.
// - Enabled watchdog keeps slow RC running even with keep bit clear.
module sck_top (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus, write channels.
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Register bus, read channels.
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CPU and watchdog.
  input wire logic stop_instruction,
  input wire logic wake_event,
  input wire logic wdt_en,
  // Oscillator levels.
  input wire logic crystal_osc,
  input wire logic fast_rc_osc,
  input wire logic slow_rc_osc,
  // Oscillator and regulator enables.
  output logic xtal_run,
  output logic fast_rc_run,
  output logic slow_rc_run,
  output logic ldo_en,
  // CPU state and delivered clocks.
  output logic cpu_run,
  output logic [2:0] op_mode,
  output logic sys_clock,
  output logic hs_clock,
  output logic sub_clock,
  output logic slow_rc_clock,
  output logic tb0_clock
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_have;
    logic w_have;
    sck_pkg::sck_idx_t aw_idx;
    logic [7:0] w_data;
    logic w_lane0;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [2:0] sys_clk_sel;
    logic hs_src_sel;
    logic hs_osc_halt_keep;
    logic ls_osc_halt_keep;
    logic deep_power_down;
    logic xtal_osc_en;
    logic radio_power_up_n;
    logic xtal_div2_sel;
    logic xtal_clk_half_sel;
    logic fast_rc_en;
    logic [2:0] osc_s1;
    logic [2:0] osc_s2;
    sck_pkg::sck_mode_t mode;
    logic cpu_run;
    logic ldo_en;
    logic hs_run;
    logic sub_run;
    logic sys_run;
    logic slow_rc_osc_run;
    logic xtal_run;
    logic fast_rc_run;
    logic hs_xtal_act;
    logic hs_lvl;
    logic sys_sub_act;
    logic sys_gate;
    logic sys_clk;
    logic hs_gate;
    logic hs_clk;
    logic sub_gate;
    logic sub_clk;
    logic slow_rc_osc_gate;
    logic slow_rc_osc_clk;
    logic tb0_clk;
  } sck_top_st_t;

  sck_top_st_t s_q;
  sck_top_st_t s_d;
  logic xtal_div_lvl;
  logic sys_div_lvl;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic sck_pkg::sck_idx_t reg_idx(input logic [31:0] a);
    case (a)
      sck_pkg::SCC_OFS: return sck_pkg::IDX_SCC;
      sck_pkg::POWER_CTRL_REG_OFS: return sck_pkg::IDX_POWER_CTRL_REG;
      sck_pkg::OSC_OFS: return sck_pkg::IDX_OSC;
      sck_pkg::STAT_OFS: return sck_pkg::IDX_STAT;
      default: return sck_pkg::IDX_NONE;
    endcase
  endfunction

  // A gate opens or closes only while its source and its output are low.
  function automatic logic gate_upd(input logic g, input logic want,
                                    input logic src, input logic out);
    return (!src && !out) ? want : g;
  endfunction

  function automatic sck_pkg::sck_mode_t stop_mode(input logic dpd,
                                                   input logic hk,
                                                   input logic lk);
    if (dpd) begin
      return sck_pkg::MODE_DEEP;
    end else if (hk && lk) begin
      return sck_pkg::MODE_IDLE_BOTH;
    end else if (hk) begin
      return sck_pkg::MODE_IDLE_HS;
    end else if (lk) begin
      return sck_pkg::MODE_IDLE_LP;
    end
    return sck_pkg::MODE_SLEEP;
  endfunction

  // ----------------------------------------------------------------------
  // Dividers
  // ----------------------------------------------------------------------
  sck_pow2_div u_xtal_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .src_lvl(s_q.osc_s2[sck_pkg::OSC_XTAL]),
    .div_exp(3'(s_q.xtal_div2_sel) + 3'(s_q.xtal_clk_half_sel)),
    .div_lvl(xtal_div_lvl)
  );

  sck_pow2_div u_sys_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .src_lvl(s_q.hs_lvl),
    .div_exp((s_q.sys_clk_sel == sck_pkg::SEL_SUB) ? sck_pkg::EXP_NONE :
             s_q.sys_clk_sel),
    .div_lvl(sys_div_lvl)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [31:0] rd;
    logic hs_cand;
    logic sys_cand;
    logic sys_src;
    logic slow_lvl;
    logic hs_own_en;
    rd = '0;
    hs_cand = 1'b0;
    sys_cand = 1'b0;
    sys_src = 1'b0;
    slow_lvl = 1'b0;
    hs_own_en = 1'b0;
    s_d = s_q;
    s_d.osc_s1 = {slow_rc_osc, fast_rc_osc, crystal_osc};
    s_d.osc_s2 = s_q.osc_s1;
    slow_lvl = s_q.osc_s2[sck_pkg::OSC_SLOW];

    // Bus writes: address and data are held independently.
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_idx = reg_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata[7:0];
      s_d.w_lane0 = s_axi_wstrb[0];
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = (s_q.aw_idx == sck_pkg::IDX_NONE) ?
                  sck_pkg::RESP_SLVERR : sck_pkg::RESP_OKAY;
      if (s_q.w_lane0) begin
        case (s_q.aw_idx)
          sck_pkg::IDX_SCC: begin
            s_d.sys_clk_sel = s_q.w_data[sck_pkg::SCC_SEL_LSB +: 3];
            s_d.hs_src_sel = s_q.w_data[sck_pkg::SCC_HS_SRC];
            s_d.hs_osc_halt_keep = s_q.w_data[sck_pkg::SCC_HS_KEEP];
            s_d.ls_osc_halt_keep = s_q.w_data[sck_pkg::SCC_LS_KEEP];
          end
          sck_pkg::IDX_POWER_CTRL_REG: begin
            s_d.deep_power_down = s_q.w_data[sck_pkg::POWER_CTRL_REG_DPD];
          end
          sck_pkg::IDX_OSC: begin
            s_d.xtal_osc_en = s_q.w_data[sck_pkg::OSC_XEN];
            s_d.radio_power_up_n = s_q.w_data[sck_pkg::OSC_RPU];
            s_d.xtal_div2_sel = s_q.w_data[sck_pkg::OSC_XDIV2];
            s_d.xtal_clk_half_sel = s_q.w_data[sck_pkg::OSC_XHALF];
            s_d.fast_rc_en = s_q.w_data[sck_pkg::OSC_FRC_EN];
          end
          default: begin
          end
        endcase
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready = !s_d.w_have && !s_d.bvalid;

    // Bus reads.
    case (reg_idx(s_axi_araddr))
      sck_pkg::IDX_SCC: begin
        rd[sck_pkg::SCC_SEL_LSB +: 3] = s_q.sys_clk_sel;
        rd[sck_pkg::SCC_HS_SRC] = s_q.hs_src_sel;
        rd[sck_pkg::SCC_HS_KEEP] = s_q.hs_osc_halt_keep;
        rd[sck_pkg::SCC_LS_KEEP] = s_q.ls_osc_halt_keep;
      end
      sck_pkg::IDX_POWER_CTRL_REG: begin
        rd[sck_pkg::POWER_CTRL_REG_DPD] = s_q.deep_power_down;
      end
      sck_pkg::IDX_OSC: begin
        rd[sck_pkg::OSC_XEN] = s_q.xtal_osc_en;
        rd[sck_pkg::OSC_RPU] = s_q.radio_power_up_n;
        rd[sck_pkg::OSC_XDIV2] = s_q.xtal_div2_sel;
        rd[sck_pkg::OSC_XHALF] = s_q.xtal_clk_half_sel;
        rd[sck_pkg::OSC_FRC_EN] = s_q.fast_rc_en;
      end
      sck_pkg::IDX_STAT: begin
        rd[sck_pkg::STAT_MODE_LSB +: 3] = s_q.mode;
        rd[sck_pkg::STAT_CPU] = s_q.cpu_run;
        rd[sck_pkg::STAT_LDO] = s_q.ldo_en;
        rd[sck_pkg::STAT_HS] = s_q.hs_run;
        rd[sck_pkg::STAT_SUB] = s_q.sub_run;
        rd[sck_pkg::STAT_SYS] = s_q.sys_run;
        rd[sck_pkg::STAT_SLOW_RC_OSC] = s_q.slow_rc_osc_run;
      end
      default: begin
      end
    endcase
    if (s_axi_arvalid && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = rd;
      s_d.rresp = (reg_idx(s_axi_araddr) == sck_pkg::IDX_NONE) ?
                  sck_pkg::RESP_SLVERR : sck_pkg::RESP_OKAY;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end

    // Operating mode.
    case (s_q.mode)
      sck_pkg::MODE_NORMAL, sck_pkg::MODE_SLOW: begin
        if (stop_instruction) begin
          s_d.mode = stop_mode(s_q.deep_power_down, s_q.hs_osc_halt_keep,
                               s_q.ls_osc_halt_keep);
        end else if (s_q.sys_clk_sel == sck_pkg::SEL_SUB) begin
          s_d.mode = sck_pkg::MODE_SLOW;
        end else begin
          s_d.mode = sck_pkg::MODE_NORMAL;
        end
      end
      sck_pkg::MODE_SLEEP, sck_pkg::MODE_IDLE_LP, sck_pkg::MODE_IDLE_BOTH,
      sck_pkg::MODE_IDLE_HS, sck_pkg::MODE_DEEP: begin
        if (wake_event) begin
          s_d.mode = (s_q.sys_clk_sel == sck_pkg::SEL_SUB) ?
                     sck_pkg::MODE_SLOW : sck_pkg::MODE_NORMAL;
        end
      end
      default: begin
        s_d.mode = sck_pkg::MODE_NORMAL;
      end
    endcase

    // Run flags follow the mode being entered.
    hs_own_en = s_q.hs_src_sel ? (s_q.xtal_osc_en && s_q.radio_power_up_n)
                               : s_q.fast_rc_en;
    s_d.cpu_run = (s_d.mode == sck_pkg::MODE_NORMAL) ||
                  (s_d.mode == sck_pkg::MODE_SLOW);
    s_d.ldo_en = (s_d.mode != sck_pkg::MODE_DEEP);
    s_d.sub_run = s_d.cpu_run || (s_d.mode == sck_pkg::MODE_IDLE_LP) ||
                  (s_d.mode == sck_pkg::MODE_IDLE_BOTH);
    case (s_d.mode)
      sck_pkg::MODE_NORMAL: s_d.hs_run = 1'b1;
      sck_pkg::MODE_SLOW: s_d.hs_run = hs_own_en;
      sck_pkg::MODE_IDLE_BOTH: s_d.hs_run = 1'b1;
      sck_pkg::MODE_IDLE_HS: s_d.hs_run = 1'b1;
      default: s_d.hs_run = 1'b0;
    endcase
    s_d.sys_run = s_d.cpu_run || (s_d.mode == sck_pkg::MODE_IDLE_BOTH) ||
                  ((s_d.mode == sck_pkg::MODE_IDLE_LP) &&
                   (s_q.sys_clk_sel == sck_pkg::SEL_SUB)) ||
                  ((s_d.mode == sck_pkg::MODE_IDLE_HS) &&
                   (s_q.sys_clk_sel != sck_pkg::SEL_SUB));
    s_d.slow_rc_osc_run = wdt_en || ((s_d.mode != sck_pkg::MODE_SLEEP) &&
                   (s_d.mode != sck_pkg::MODE_DEEP));
    s_d.xtal_run = s_q.xtal_osc_en && s_q.radio_power_up_n &&
                   (s_d.cpu_run || (s_d.hs_run && s_q.hs_src_sel));
    s_d.fast_rc_run = (s_q.fast_rc_en && s_d.cpu_run) ||
                      (s_d.hs_run && !s_q.hs_src_sel);

    // High-speed source switch.
    hs_cand = s_q.hs_src_sel ? xtal_div_lvl :
              s_q.osc_s2[sck_pkg::OSC_FRC];
    if (s_q.hs_src_sel != s_q.hs_xtal_act && !s_q.hs_lvl && !hs_cand) begin
      s_d.hs_xtal_act = s_q.hs_src_sel;
    end
    s_d.hs_lvl = s_d.hs_xtal_act ? xtal_div_lvl :
                 s_q.osc_s2[sck_pkg::OSC_FRC];

    // System clock source switch and gate.
    sys_cand = (s_q.sys_clk_sel == sck_pkg::SEL_SUB) ? slow_lvl :
               sys_div_lvl;
    if ((s_q.sys_clk_sel == sck_pkg::SEL_SUB) != s_q.sys_sub_act &&
        !s_q.sys_clk && !sys_cand) begin
      s_d.sys_sub_act = (s_q.sys_clk_sel == sck_pkg::SEL_SUB);
    end
    sys_src = s_d.sys_sub_act ? slow_lvl : sys_div_lvl;
    s_d.sys_gate = gate_upd(s_q.sys_gate, s_d.sys_run, sys_src, s_q.sys_clk);
    s_d.sys_clk = s_d.sys_gate && sys_src;
    s_d.hs_gate = gate_upd(s_q.hs_gate, s_d.hs_run, s_q.hs_lvl, s_q.hs_clk);
    s_d.hs_clk = s_d.hs_gate && s_q.hs_lvl;
    s_d.sub_gate = gate_upd(s_q.sub_gate, s_d.sub_run, slow_lvl,
                            s_q.sub_clk);
    s_d.sub_clk = s_d.sub_gate && slow_lvl;
    s_d.slow_rc_osc_gate = gate_upd(s_q.slow_rc_osc_gate, s_d.slow_rc_osc_run, slow_lvl,
                             s_q.slow_rc_osc_clk);
    s_d.slow_rc_osc_clk = s_d.slow_rc_osc_gate && slow_lvl;
    s_d.tb0_clk = (s_q.mode == sck_pkg::MODE_DEEP) ? s_q.slow_rc_osc_clk :
                  s_q.sub_clk;

    if (!aresetn) begin
      s_d = '0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
      s_d.arready = 1'b1;
      s_d.aw_idx = sck_pkg::IDX_NONE;
      s_d.sys_clk_sel = sck_pkg::SEL_RST;
      s_d.fast_rc_en = sck_pkg::FRC_EN_RST;
      s_d.mode = sck_pkg::MODE_NORMAL;
      s_d.cpu_run = 1'b1;
      s_d.ldo_en = 1'b1;
      s_d.hs_run = 1'b1;
      s_d.sub_run = 1'b1;
      s_d.sys_run = 1'b1;
      s_d.slow_rc_osc_run = 1'b1;
      s_d.fast_rc_run = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign xtal_run = s_q.xtal_run;
  assign fast_rc_run = s_q.fast_rc_run;
  assign slow_rc_run = s_q.slow_rc_osc_run;
  assign ldo_en = s_q.ldo_en;
  assign cpu_run = s_q.cpu_run;
  assign op_mode = s_q.mode;
  assign sys_clock = s_q.sys_clk;
  assign hs_clock = s_q.hs_clk;
  assign sub_clock = s_q.sub_clk;
  assign slow_rc_clock = s_q.slow_rc_osc_clk;
  assign tb0_clock = s_q.tb0_clk;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic run_q;
  assign run_q = (s_q.mode == sck_pkg::MODE_NORMAL) ||
                 (s_q.mode == sck_pkg::MODE_SLOW);

  a_cpu_run_modes: assert property (s_q.cpu_run == run_q)
    else $error("cpu run flag disagrees with mode");
  a_normal_clocks: assert property ((s_q.mode == sck_pkg::MODE_NORMAL)
    |-> (s_q.ldo_en && s_q.hs_run && s_q.sub_run && s_q.slow_rc_osc_run))
    else $error("normal mode lost a clock or regulator");
  a_slow_sub: assert property ((s_q.mode == sck_pkg::MODE_SLOW &&
    s_q.sys_clk_sel == sck_pkg::SEL_SUB && !s_q.sys_clk &&
    !s_q.osc_s2[sck_pkg::OSC_SLOW]) |=> s_q.sys_sub_act)
    else $error("slow mode not switched to sub clock");
  a_stop_sleep: assert property ((run_q && stop_instruction &&
    !s_q.deep_power_down && !s_q.hs_osc_halt_keep && !s_q.ls_osc_halt_keep)
    |=> (s_q.mode == sck_pkg::MODE_SLEEP && !s_q.sys_run &&
         !s_q.hs_run && s_q.ldo_en))
    else $error("stop did not enter sleep");
  a_stop_idle_lp: assert property ((run_q && stop_instruction &&
    !s_q.deep_power_down && !s_q.hs_osc_halt_keep && s_q.ls_osc_halt_keep)
    |=> (s_q.mode == sck_pkg::MODE_IDLE_LP && s_q.sub_run &&
         !s_q.hs_run))
    else $error("stop did not enter low-speed idle");
  a_stop_idle_both: assert property ((run_q && stop_instruction &&
    !s_q.deep_power_down && s_q.hs_osc_halt_keep && s_q.ls_osc_halt_keep)
    |=> (s_q.mode == sck_pkg::MODE_IDLE_BOTH && s_q.sys_run &&
         s_q.hs_run && s_q.sub_run))
    else $error("stop did not enter idle with both clocks");
  a_stop_idle_hs: assert property ((run_q && stop_instruction &&
    !s_q.deep_power_down && s_q.hs_osc_halt_keep && !s_q.ls_osc_halt_keep)
    |=> (s_q.mode == sck_pkg::MODE_IDLE_HS && !s_q.sub_run &&
         s_q.hs_run))
    else $error("stop did not enter high-speed idle");
  a_stop_deep: assert property ((run_q && stop_instruction &&
    s_q.deep_power_down) |=> (s_q.mode == sck_pkg::MODE_DEEP &&
    !s_q.ldo_en && !s_q.sys_run && !s_q.cpu_run))
    else $error("stop did not enter deep sleep");
  a_slow_rc_osc_off: assert property (((s_q.mode == sck_pkg::MODE_SLEEP ||
    s_q.mode == sck_pkg::MODE_DEEP) && !wdt_en && !wake_event)
    |=> !slow_rc_run)
    else $error("slow RC runs without watchdog in sleep");
  a_slow_rc_osc_wdt: assert property (wdt_en |=> slow_rc_run)
    else $error("slow RC stopped with watchdog on");
  a_sys_no_runt: assert property ($rose(sys_clock) |=> sys_clock)
    else $error("runt high pulse on system clock");

  c_deep: cover property (run_q ##1 s_q.mode == sck_pkg::MODE_DEEP);
  c_idle_both: cover property (s_q.mode == sck_pkg::MODE_IDLE_BOTH);
  c_wake: cover property (!run_q ##1 run_q);
  c_to_sub: cover property ($rose(s_q.sys_sub_act));

endmodule

/* bench/sck_osc_model.sv */
`timescale 1ns/1ps
module sck_osc_model (
  // Run enables from the block.
  input wire logic xtal_run,
  input wire logic fast_rc_run,
  input wire logic slow_rc_run,
  // Oscillator levels.
  output logic crystal_osc,
  output logic fast_rc_osc,
  output logic slow_rc_osc
);
  // A stopped oscillator rests low, so a gate that wrongly stays open
  // shows no edges at all rather than a stale level.
  initial begin
    crystal_osc = 1'h0;
    fast_rc_osc = 1'h0;
    slow_rc_osc = 1'h0;
  end
  always #17 crystal_osc = xtal_run && !crystal_osc;
  always #23 fast_rc_osc = fast_rc_run && !fast_rc_osc;
  always #37 slow_rc_osc = slow_rc_run && !slow_rc_osc;
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [2:0] s_axi_awprot, s_axi_arprot, op_mode;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, stop_instruction;
  logic wake_event, wdt_en, crystal_osc, fast_rc_osc, slow_rc_osc;
  logic xtal_run, fast_rc_run, slow_rc_run, ldo_en, cpu_run, sys_clock;
  logic hs_clock, sub_clock, slow_rc_clock, tb0_clock;
  logic [15:0] rnd = 16'h7925;
  int num_errors = 0, check_count = 0, sel, hk, lk, dp, w, x;

  sck_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .stop_instruction, .wake_event, .wdt_en, .crystal_osc,
    .fast_rc_osc, .slow_rc_osc, .xtal_run, .fast_rc_run, .slow_rc_run,
    .ldo_en, .cpu_run, .op_mode, .sys_clock, .hs_clock, .sub_clock,
    .slow_rc_clock, .tb0_clock);
  sck_osc_model osc (.xtal_run, .fast_rc_run, .slow_rc_run, .crystal_osc,
    .fast_rc_osc, .slow_rc_osc);

  initial begin
    aclk = 1'h0;
    forever #5 aclk = !aclk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected status word: mode, cpu, regulator, hs, sub, sys, slow RC.
  function automatic logic [31:0] ex(input int stp);
    int m, hs, sb, sy, lr;
    m = !stp ? sel == 7 : dp ? 6 : hk ? (lk ? 4 : 5) : (lk ? 3 : 2);
    hs = m < 2 || m == 4 || m == 5;
    sb = m < 2 || m == 3 || m == 4;
    sy = m < 2 || m == 4 || m == 3 && sel == 7 || m == 5 && sel != 7;
    lr = w || m != 2 && m != 6;
    return 32'(lr * 256 + sy * 128 + sb * 64 + hs * 32 + (m != 6) * 16
      + (m < 2) * 8 + m);
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [31:0] a, v, output logic [1:0] b);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      ad |= s_axi_awready;
      wd |= s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end
    while (!s_axi_bvalid) @(posedge aclk);
    b = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] v,
                    output logic [1:0] b);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    @(posedge aclk);
    while (!s_axi_arready) @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    @(posedge aclk);
    while (!s_axi_rvalid) @(posedge aclk);
    v = s_axi_rdata;
    b = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic pulse(input bit wk);
    @(posedge aclk);
    wake_event <= wk;
    stop_instruction <= !wk;
    @(posedge aclk);
    wake_event <= 1'h0;
    stop_instruction <= 1'h0;
    #1;
  endtask

  task automatic look(input int stp);
    logic [31:0] e;
    logic [4:0] v, p, t, q;
    e = ex(stp);
    chk(32'(op_mode), 32'(e[2:0]));
    chk(32'({ldo_en, cpu_run}), 32'(e[4:3]));
    q = 5'({x && e[5], e[3] || e[5] && !x, e[8]});
    chk(32'({xtal_run, fast_rc_run, slow_rc_run}), 32'(q));
    rd(sck_pkg::STAT_OFS, d, r);
    chk(d, e);
    repeat (8) @(posedge aclk);
    // Edges are counted, not levels, since a stopped clock may rest high.
    p = {tb0_clock, slow_rc_clock, sys_clock, sub_clock, hs_clock};
    t = '0;
    repeat (300) begin
      @(posedge aclk);
      v = {tb0_clock, slow_rc_clock, sys_clock, sub_clock, hs_clock};
      t |= v ^ p;
      p = v;
    end
    q = {e[2:0] == 3'h6 ? e[8] : e[6], e[8], e[7], e[6], e[5]};
    chk(32'(t), 32'(q));
  endtask

  task automatic results();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge aclk);
    num_errors++;
    results();
  end

  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awprot, s_axi_arprot, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {stop_instruction, wake_event, wdt_en, aresetn} = '0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    rd(sck_pkg::SCC_OFS, d, r);
    chk(d, 32'h0000_0020);
    rd(32'h0000_0010, d, r);
    chk(d, 32'h0000_0000);
    chk(32'(r), 32'(sck_pkg::RESP_SLVERR));
    wr(32'h0000_0010, 32'h0000_00FF, r);
    chk(32'(r), 32'(sck_pkg::RESP_SLVERR));
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      sel = i >= 16 ? 7 : int'(rnd) % 7;
      lk = i & 1;
      hk = i >> 1 & 1;
      dp = i >> 2 & 1;
      w = rnd[4];
      @(posedge aclk) wdt_en <= rnd[4];
      wr(sck_pkg::SCC_OFS, 32'(sel * 32 + hk * 2 + lk), r);
      wr(sck_pkg::POWER_CTRL_REG_OFS, 32'(dp), r);
      chk(32'(r), 32'(sck_pkg::RESP_OKAY));
      look(0);
      pulse(0);
      look(1);
      pulse(0);
      chk(32'(op_mode), 32'(ex(1) & 7));
      pulse(1);
      chk(32'(op_mode), 32'(sel == 7));
    end
    // Crystal halved as the high-speed source, then slow mode with it off.
    x = 1;
    sel = 0;
    wr(sck_pkg::OSC_OFS, 32'h0000_0017, r);
    wr(sck_pkg::SCC_OFS, 32'h0000_0008, r);
    rd(sck_pkg::OSC_OFS, d, r);
    chk(d, 32'h0000_0017);
    look(0);
    wr(sck_pkg::SCC_OFS, 32'h0000_00E8, r);
    wr(sck_pkg::OSC_OFS, 32'h0000_0016, r);
    rd(sck_pkg::STAT_OFS, d, r);
    chk(d, 32'h0000_01D9);
    results();
  end
endmodule
